/* ricb_defs.svh */
// Register offsets, field positions, reset values and rate constants of the radio register bank.
`ifndef RICB_DEFS_SVH
`define RICB_DEFS_SVH

`define RICB_OFS_AGC_RATE_DIVIDER 10'h32f
`define RICB_OFS_IRQ_SOURCE_PRIMARY 10'h336
`define RICB_OFS_IRQ_SOURCE_SECONDARY 10'h337
`define RICB_OFS_CALIBRATION_ENABLE 10'h338
`define RICB_OFS_CALIBRATION_STATE 10'h339
`define RICB_OFS_IFCAL_WORD_READBACK 10'h345
`define RICB_OFS_IFCAL_WORD_OVERRIDE 10'h346
`define RICB_OFS_RC_OSC_TRIM_RESULT_HI 10'h34f
`define RICB_OFS_RC_OSC_TRIM_RESULT_LO 10'h350
`define RICB_OFS_ADC_INPUT_VREF_SELECT 10'h359

`define RICB_RST_AGC_RATE_DIVIDER 8'h28
`define RICB_RST_ZERO 8'h00

`define RICB_BIT_WAKEUP_COUNT 7
`define RICB_BIT_SMART_WAKE 6
`define RICB_BIT_AES_DONE 5
`define RICB_BIT_TX_DONE 4
`define RICB_BIT_ADDR_MATCH 3
`define RICB_BIT_CRC_OK 2
`define RICB_BIT_SYNC_FOUND 1
`define RICB_BIT_PREAMBLE_FOUND 0
`define RICB_BIT_SUPPLY_ALARM 7
`define RICB_BIT_CMD_ACCEPT 6
`define RICB_BIT_WAKE_TIMER 4
`define RICB_BIT_SERIAL_READY 1
`define RICB_BIT_CMD_DONE 0
`define RICB_BIT_PLL_CAL 1
`define RICB_BIT_IF_FILTER_CAL 0
`define RICB_BIT_PA_RAMP 2

`define RICB_REF_CLK_MHZ 17'd26
`define RICB_SYS_CLK_MHZ 17'd10
`define RICB_AGC_PRESCALE 17'd16
`define RICB_ALARM_BASE_MV 12'd1700
`define RICB_ALARM_STEP_MV 12'd62

`endif

/* ricb_pkg.sv */
// Types shared by the radio register bank.
package ricb_pkg;
  typedef logic [9:0] ricb_addr_t;
  typedef logic [7:0] ricb_byte_t;
  typedef logic [5:0] ricb_calword_t;
endpackage

/* ricb_register_bank.sv */
// Control and status register bank of the packet radio: interrupt sources, calibration, gain rate.
`timescale 1ns/1ps
`default_nettype none
`include "ricb_defs.svh"

// Summary of operation
// - Gain loop tick at 26MHz/(16*divider), reset 40.
// - Primary bit7 on wakeup count reaching limit.
// - Primary bit6 when smart wake strength exceeds.
// - Primary bit5 on AES done, module loaded.
// - Primary bit4 on transmit done, packet mode.
// - Primary bit3 on address match, packet mode.
// - Primary bit2 on good CRC, packet mode.
// - Primary bit1 on qualified sync word.
// - Primary bit0 on qualified preamble.
// - Secondary bit7 when supply below alarm level.
// - Secondary bit6 command accept, bit0 done.
// - Secondary bit4 timer expiry, bit1 serial ready.
// - Calibration bit1 enables synthesizer calibration.
// - Calibration bit0 enables filter calibration.
// - Status bit1 shows synthesizer calibration done.
// - Status bit0 shows filter calibration done while enable bit0 is set.
// - Filter calibration word readable, read only.
// - Override bit0 selects forced word bits6:1.
// - RC oscillator result as two bytes.
// - Alarm trip is 1.7V plus 62mV*(code+1).
module ricb_register_bank (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Register access from the serial control interface.
  input wire ricb_pkg::ricb_addr_t reg_addr,
  input wire logic reg_wr,
  input wire ricb_pkg::ricb_byte_t reg_wdata,
  input wire logic reg_rd,
  output var ricb_pkg::ricb_byte_t reg_rdata,
  // Wake-up controller.
  input wire logic [15:0] wakeup_counter,
  input wire logic [15:0] wakeup_count_limit,
  input wire logic wake_timer_expired,
  input wire logic smart_wake_active,
  input wire ricb_pkg::ricb_byte_t smart_wake_strength,
  input wire ricb_pkg::ricb_byte_t smart_wake_strength_limit,
  // Packet handling and processor events.
  input wire logic packet_mode,
  input wire logic aes_module_loaded,
  input wire logic aes_done,
  input wire logic tx_done,
  input wire logic addr_match,
  input wire logic crc_ok,
  input wire logic sync_found,
  input wire logic preamble_found,
  input wire logic cmd_accept,
  input wire logic cmd_done,
  input wire logic serial_ready,
  // Supply monitor.
  input wire logic supply_monitor_on,
  input wire logic [11:0] supply_mv,
  input wire logic [4:0] supply_alarm_level,
  // Calibration engines.
  input wire logic pll_cal_done,
  input wire logic if_filter_cal_done,
  input wire logic pa_ramp_finished,
  input wire ricb_pkg::ricb_calword_t if_filter_cal_word,
  input wire logic [15:0] rc_osc_trim_result,
  // Controls to the radio.
  output var logic gain_loop_tick,
  output var logic pll_cal_enable,
  output var logic if_filter_cal_enable,
  output var ricb_pkg::ricb_calword_t if_filter_word_used,
  output var logic [1:0] adc_input_select,
  output var logic [1:0] adc_vref_select
);
  import ricb_pkg::*;

  typedef struct packed {
    ricb_byte_t rdata;
    ricb_byte_t divider;
    logic [16:0] rate_acc;
    logic tick;
    ricb_byte_t src0;
    ricb_byte_t src1;
    logic [1:0] cal_en;
    logic [6:0] override;
    ricb_byte_t rc_hi;
    ricb_byte_t rc_lo;
    logic [3:0] adc_sel;
    ricb_calword_t word_used;
    logic wake_hit;
    logic strength_hit;
    logic supply_low;
  } ricb_state_s;

  ricb_state_s st_q;
  ricb_state_s st_d;

  function automatic logic [11:0] ricb_trip_mv(input logic [4:0] code);
    logic [11:0] steps;
    steps = 12'({7'h00, code} + 12'd1);
    ricb_trip_mv = 12'(`RICB_ALARM_BASE_MV + 12'(`RICB_ALARM_STEP_MV * steps));
  endfunction

  function automatic logic ricb_hit(input ricb_addr_t a, input ricb_addr_t ofs);
    ricb_hit = (a == ofs);
  endfunction

  logic wake_hit_now;
  logic strength_hit_now;
  logic supply_low_now;
  logic [16:0] rate_limit;
  logic [16:0] rate_next;
  ricb_byte_t ev0;
  ricb_byte_t ev1;

  always_comb begin
    wake_hit_now = (wakeup_counter == wakeup_count_limit);
    strength_hit_now = smart_wake_active && (smart_wake_strength > smart_wake_strength_limit);
    supply_low_now = supply_monitor_on && (supply_mv < ricb_trip_mv(supply_alarm_level));
    rate_limit = 17'(`RICB_AGC_PRESCALE * `RICB_SYS_CLK_MHZ * {9'h000, st_q.divider});
    rate_next = 17'(st_q.rate_acc + `RICB_REF_CLK_MHZ);
    ev0 = 8'h00;
    ev0[`RICB_BIT_WAKEUP_COUNT] = wake_hit_now && !st_q.wake_hit;
    ev0[`RICB_BIT_SMART_WAKE] = strength_hit_now && !st_q.strength_hit;
    ev0[`RICB_BIT_AES_DONE] = aes_done && aes_module_loaded;
    ev0[`RICB_BIT_TX_DONE] = tx_done && packet_mode;
    ev0[`RICB_BIT_ADDR_MATCH] = addr_match && packet_mode;
    ev0[`RICB_BIT_CRC_OK] = crc_ok && packet_mode;
    ev0[`RICB_BIT_SYNC_FOUND] = sync_found;
    ev0[`RICB_BIT_PREAMBLE_FOUND] = preamble_found;
    ev1 = 8'h00;
    ev1[`RICB_BIT_SUPPLY_ALARM] = supply_low_now && !st_q.supply_low;
    ev1[`RICB_BIT_CMD_ACCEPT] = cmd_accept;
    ev1[`RICB_BIT_CMD_DONE] = cmd_done;
    ev1[`RICB_BIT_WAKE_TIMER] = wake_timer_expired;
    ev1[`RICB_BIT_SERIAL_READY] = serial_ready;
  end

  always_comb begin
    st_d = st_q;
    st_d.wake_hit = wake_hit_now;
    st_d.strength_hit = strength_hit_now;
    st_d.supply_low = supply_low_now;
    // The accumulator averages the reference rate exactly on the slower system clock.
    st_d.tick = 1'b0;
    if (st_q.divider == 8'h00) begin
      st_d.rate_acc = 17'h00000;
    end else if (rate_next >= rate_limit) begin
      st_d.rate_acc = 17'(rate_next - rate_limit);
      st_d.tick = 1'b1;
    end else begin
      st_d.rate_acc = rate_next;
    end
    // Result bytes follow the calibration engine continuously.
    st_d.rc_hi = rc_osc_trim_result[15:8];
    st_d.rc_lo = rc_osc_trim_result[7:0];
    st_d.word_used = st_q.override[0] ? st_q.override[6:1] : if_filter_cal_word;
    // A host write replaces a source register, and a same-cycle event still sets its bit.
    st_d.src0 = st_q.src0 | ev0;
    st_d.src1 = st_q.src1 | ev1;
    if (reg_wr) begin
      if (ricb_hit(reg_addr, `RICB_OFS_AGC_RATE_DIVIDER)) begin
        st_d.divider = reg_wdata;
        st_d.rate_acc = 17'h00000;
      end
      if (ricb_hit(reg_addr, `RICB_OFS_IRQ_SOURCE_PRIMARY)) begin
        st_d.src0 = reg_wdata | ev0;
      end
      if (ricb_hit(reg_addr, `RICB_OFS_IRQ_SOURCE_SECONDARY)) begin
        st_d.src1 = reg_wdata | ev1;
      end
      if (ricb_hit(reg_addr, `RICB_OFS_CALIBRATION_ENABLE)) begin
        st_d.cal_en = reg_wdata[1:0];
      end
      if (ricb_hit(reg_addr, `RICB_OFS_IFCAL_WORD_OVERRIDE)) begin
        st_d.override = reg_wdata[6:0];
      end
      if (ricb_hit(reg_addr, `RICB_OFS_ADC_INPUT_VREF_SELECT)) begin
        st_d.adc_sel = reg_wdata[3:0];
      end
    end
    // Reads answer one cycle later; unmapped offsets read zero.
    if (reg_rd) begin
      unique case (reg_addr)
        `RICB_OFS_AGC_RATE_DIVIDER: st_d.rdata = st_q.divider;
        `RICB_OFS_IRQ_SOURCE_PRIMARY: st_d.rdata = st_q.src0;
        `RICB_OFS_IRQ_SOURCE_SECONDARY: st_d.rdata = st_q.src1;
        `RICB_OFS_CALIBRATION_ENABLE: st_d.rdata = {6'h00, st_q.cal_en};
        `RICB_OFS_CALIBRATION_STATE: begin
          st_d.rdata = {5'h00, pa_ramp_finished, pll_cal_done,
                        if_filter_cal_done && st_q.cal_en[`RICB_BIT_IF_FILTER_CAL]};
        end
        `RICB_OFS_IFCAL_WORD_READBACK: st_d.rdata = {2'h0, if_filter_cal_word};
        `RICB_OFS_IFCAL_WORD_OVERRIDE: st_d.rdata = {1'b0, st_q.override};
        `RICB_OFS_RC_OSC_TRIM_RESULT_HI: st_d.rdata = st_q.rc_hi;
        `RICB_OFS_RC_OSC_TRIM_RESULT_LO: st_d.rdata = st_q.rc_lo;
        `RICB_OFS_ADC_INPUT_VREF_SELECT: st_d.rdata = {4'h0, st_q.adc_sel};
        default: st_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q <= '0;
      st_q.divider <= `RICB_RST_AGC_RATE_DIVIDER;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;
  assign gain_loop_tick = st_q.tick;
  assign pll_cal_enable = st_q.cal_en[`RICB_BIT_PLL_CAL];
  assign if_filter_cal_enable = st_q.cal_en[`RICB_BIT_IF_FILTER_CAL];
  assign if_filter_word_used = st_q.word_used;
  assign adc_input_select = st_q.adc_sel[3:2];
  assign adc_vref_select = st_q.adc_sel[1:0];

  // Checks on the bank's own behaviour.
  property p_tick_spacing;
    @(posedge clk) disable iff (!reset_n)
    (gain_loop_tick && st_q.divider == 8'h28) |=> !gain_loop_tick [*8];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("gain tick too close");

  property p_no_tick_zero;
    @(posedge clk) disable iff (!reset_n)
    (st_q.divider == 8'h00 && $past(st_q.divider) == 8'h00) |-> !gain_loop_tick;
  endproperty
  a_no_tick_zero: assert property (p_no_tick_zero) else $error("tick with zero divider");

  property p_wake_count;
    @(posedge clk) disable iff (!reset_n)
    (wakeup_counter == wakeup_count_limit && !st_q.wake_hit) |=> st_q.src0[7];
  endproperty
  a_wake_count: assert property (p_wake_count) else $error("wakeup count bit not set");

  property p_aes_gate;
    @(posedge clk) disable iff (!reset_n)
    (aes_done && !aes_module_loaded && !reg_wr && !st_q.src0[5]) |=> !st_q.src0[5];
  endproperty
  a_aes_gate: assert property (p_aes_gate) else $error("aes bit set without module");

  property p_tx_gate;
    @(posedge clk) disable iff (!reset_n)
    (tx_done && !packet_mode && !reg_wr) |=> st_q.src0[4] == $past(st_q.src0[4]);
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("tx bit moved outside packet mode");

  property p_crc_set;
    @(posedge clk) disable iff (!reset_n)
    (crc_ok && packet_mode) |=> st_q.src0[2] ##1 (st_q.src0[2] || $past(reg_wr));
  endproperty
  a_crc_set: assert property (p_crc_set) else $error("crc bit not held");

  property p_supply_alarm;
    @(posedge clk) disable iff (!reset_n)
    (supply_monitor_on && supply_mv < ricb_trip_mv(supply_alarm_level) && !st_q.supply_low)
      |=> st_q.src1[7];
  endproperty
  a_supply_alarm: assert property (p_supply_alarm) else $error("supply alarm missed");

  property p_cal_write;
    @(posedge clk) disable iff (!reset_n)
    (reg_wr && reg_addr == `RICB_OFS_CALIBRATION_ENABLE) |=> (pll_cal_enable == $past(reg_wdata[1]));
  endproperty
  a_cal_write: assert property (p_cal_write) else $error("pll cal enable wrong");

  property p_override;
    @(posedge clk) disable iff (!reset_n)
    (st_q.override[0] && $stable(st_q.override)) |=> if_filter_word_used == $past(st_q.override[6:1]);
  endproperty
  a_override: assert property (p_override) else $error("forced word not used");

  property p_set_wins;
    @(posedge clk) disable iff (!reset_n)
    (reg_wr && reg_addr == 10'h336 && preamble_found) |=> st_q.src0[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("preamble lost under write");

  property p_smart_wake;
    @(posedge clk) disable iff (!reset_n)
    (smart_wake_active && smart_wake_strength > smart_wake_strength_limit && !st_q.strength_hit)
      |=> st_q.src0[`RICB_BIT_SMART_WAKE];
  endproperty
  a_smart_wake: assert property (p_smart_wake) else $error("smart wake bit not set");

  property p_aes_set;
    @(posedge clk) disable iff (!reset_n)
    (aes_done && aes_module_loaded) |=> st_q.src0[`RICB_BIT_AES_DONE];
  endproperty
  a_aes_set: assert property (p_aes_set) else $error("aes done bit not set");

  property p_tx_set;
    @(posedge clk) disable iff (!reset_n)
    (tx_done && packet_mode) |=> st_q.src0[`RICB_BIT_TX_DONE];
  endproperty
  a_tx_set: assert property (p_tx_set) else $error("transmit done bit not set");

  property p_addr_set;
    @(posedge clk) disable iff (!reset_n)
    (addr_match && packet_mode) |=> st_q.src0[`RICB_BIT_ADDR_MATCH];
  endproperty
  a_addr_set: assert property (p_addr_set) else $error("address match bit not set");

  property p_sync_set;
    @(posedge clk) disable iff (!reset_n)
    sync_found |=> st_q.src0[`RICB_BIT_SYNC_FOUND];
  endproperty
  a_sync_set: assert property (p_sync_set) else $error("sync bit not set");

  property p_preamble_set;
    @(posedge clk) disable iff (!reset_n)
    preamble_found |=> st_q.src0[`RICB_BIT_PREAMBLE_FOUND];
  endproperty
  a_preamble_set: assert property (p_preamble_set) else $error("preamble bit not set");

  property p_cmd_accept;
    @(posedge clk) disable iff (!reset_n)
    cmd_accept |=> st_q.src1[`RICB_BIT_CMD_ACCEPT];
  endproperty
  a_cmd_accept: assert property (p_cmd_accept) else $error("command accept bit not set");

  property p_cmd_done;
    @(posedge clk) disable iff (!reset_n)
    cmd_done |=> st_q.src1[`RICB_BIT_CMD_DONE];
  endproperty
  a_cmd_done: assert property (p_cmd_done) else $error("command done bit not set");

  property p_timer_set;
    @(posedge clk) disable iff (!reset_n)
    wake_timer_expired |=> st_q.src1[`RICB_BIT_WAKE_TIMER];
  endproperty
  a_timer_set: assert property (p_timer_set) else $error("timer expiry bit not set");

  property p_serial_ready;
    @(posedge clk) disable iff (!reset_n)
    serial_ready |=> st_q.src1[`RICB_BIT_SERIAL_READY];
  endproperty
  a_serial_ready: assert property (p_serial_ready) else $error("serial ready bit not set");

  property p_filter_cal_write;
    @(posedge clk) disable iff (!reset_n)
    (reg_wr && reg_addr == `RICB_OFS_CALIBRATION_ENABLE) |=> (if_filter_cal_enable == $past(reg_wdata[0]));
  endproperty
  a_filter_cal_write: assert property (p_filter_cal_write) else $error("filter cal enable wrong");

  property p_pll_status;
    @(posedge clk) disable iff (!reset_n)
    (reg_rd && reg_addr == `RICB_OFS_CALIBRATION_STATE)
      |=> (reg_rdata[`RICB_BIT_PLL_CAL] == $past(pll_cal_done));
  endproperty
  a_pll_status: assert property (p_pll_status) else $error("pll status read wrong");

  property p_filter_status;
    @(posedge clk) disable iff (!reset_n)
    (reg_rd && reg_addr == `RICB_OFS_CALIBRATION_STATE)
      |=> (reg_rdata[`RICB_BIT_IF_FILTER_CAL] == ($past(if_filter_cal_done) && $past(if_filter_cal_enable)));
  endproperty
  a_filter_status: assert property (p_filter_status) else $error("filter status read wrong");

  property p_word_readback;
    @(posedge clk) disable iff (!reset_n)
    (reg_rd && reg_addr == `RICB_OFS_IFCAL_WORD_READBACK) |=> (reg_rdata == {2'h0, $past(if_filter_cal_word)});
  endproperty
  a_word_readback: assert property (p_word_readback) else $error("cal word read wrong");

  property p_cal_word_used;
    @(posedge clk) disable iff (!reset_n)
    !st_q.override[0] |=> (if_filter_word_used == $past(if_filter_cal_word));
  endproperty
  a_cal_word_used: assert property (p_cal_word_used) else $error("calibrated word not used");

  property p_divider_write;
    @(posedge clk) disable iff (!reset_n)
    (reg_wr && reg_addr == `RICB_OFS_AGC_RATE_DIVIDER) |=> (st_q.divider == $past(reg_wdata));
  endproperty
  a_divider_write: assert property (p_divider_write) else $error("divider write lost");

endmodule
`default_nettype wire

/* ricb_host_model.sv */
// Host model that issues register reads and writes on the serial control port.
`timescale 1ns/1ps
`default_nettype none
module ricb_host_model (
  // Clock.
  input wire logic clk,
  // Register access port.
  output var ricb_pkg::ricb_addr_t reg_addr,
  output var logic reg_wr,
  output var ricb_pkg::ricb_byte_t reg_wdata,
  output var logic reg_rd,
  input wire ricb_pkg::ricb_byte_t reg_rdata
);
  import ricb_pkg::*;
  initial begin
    reg_addr = 10'h000;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // Writes set enables and clear handled sources; idle lines show inverted values.
  task automatic wr(input ricb_addr_t a, input ricb_byte_t d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input ricb_addr_t a, output ricb_byte_t d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

/* tb.sv */
// Self-checking testbench of the radio register bank.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ricb_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  ricb_addr_t reg_addr;
  logic reg_wr;
  logic reg_rd;
  ricb_byte_t reg_wdata;
  ricb_byte_t reg_rdata;
  logic [7:0] pev = 8'h00;
  logic [7:0] sev = 8'h00;
  logic pkt = 1'b1;
  logic aes_ld = 1'b1;
  logic swm = 1'b1;
  logic [4:0] lvl = 5'h00;
  logic pll_done = 1'b0;
  logic if_done = 1'b0;
  logic pa_done = 1'b0;
  ricb_calword_t cal_word = 6'h00;
  ricb_calword_t word_used;
  logic [15:0] rc_res = 16'h0000;
  logic tick;
  logic pll_en;
  logic if_en;
  logic [1:0] adc_in;
  logic [1:0] adc_ref;
  int miscompares = 0;
  int cmp_count = 0;
  int ticks = 0;
  always #50 clk = ~clk;
  always @(posedge clk) begin
    if (tick === 1'b1) ticks <= ticks + 1;
  end
  ricb_host_model u_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  ricb_register_bank u_dut (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .wakeup_counter(pev[7] ? 16'h0005 : 16'h0000), .wakeup_count_limit(16'h0005),
    .wake_timer_expired(sev[4]), .smart_wake_active(swm),
    .smart_wake_strength(pev[6] ? 8'h81 : 8'h10), .smart_wake_strength_limit(8'h80),
    .packet_mode(pkt), .aes_module_loaded(aes_ld), .aes_done(pev[5]), .tx_done(pev[4]),
    .addr_match(pev[3]), .crc_ok(pev[2]), .sync_found(pev[1]), .preamble_found(pev[0]),
    .cmd_accept(sev[6]), .cmd_done(sev[0]), .serial_ready(sev[1]), .supply_monitor_on(1'b1),
    .supply_mv(sev[7] ? 12'h6e1 : 12'hbb8), .supply_alarm_level(lvl),
    .pll_cal_done(pll_done), .if_filter_cal_done(if_done), .pa_ramp_finished(pa_done),
    .if_filter_cal_word(cal_word), .rc_osc_trim_result(rc_res), .gain_loop_tick(tick),
    .pll_cal_enable(pll_en), .if_filter_cal_enable(if_en), .if_filter_word_used(word_used),
    .adc_input_select(adc_in), .adc_vref_select(adc_ref));
  task automatic chk(input ricb_byte_t got, input ricb_byte_t exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rc(input ricb_addr_t a, input ricb_byte_t e);
    ricb_byte_t d;
    u_host.rd(a, d);
    chk(d, e);
  endtask
  task automatic t_reset;
    ricb_addr_t zr[10] = '{10'h336, 10'h337, 10'h338, 10'h339, 10'h345, 10'h346, 10'h34f,
      10'h350, 10'h359, 10'h300};
    rc(10'h32f, 8'h28);
    for (int i = 0; i < 10; i++) rc(zr[i], 8'h00);
  endtask
  task automatic t_events(input ricb_addr_t a, input ricb_byte_t used, input logic sec);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      if (sec) sev = ricb_byte_t'(8'h01 << i);
      else pev = ricb_byte_t'(8'h01 << i);
      @(negedge clk);
      sev = 8'h00;
      pev = 8'h00;
      rc(a, ricb_byte_t'((8'h01 << i) & used));
      u_host.wr(a, 8'h00);
      rc(a, 8'h00);
    end
  endtask
  task automatic t_gates;
    pkt = 1'b0;
    aes_ld = 1'b0;
    swm = 1'b0;
    @(negedge clk);
    pev = 8'h7c;
    @(negedge clk);
    pev = 8'h00;
    rc(10'h336, 8'h00);
    pkt = 1'b1;
    aes_ld = 1'b1;
    swm = 1'b1;
    @(negedge clk);
    lvl = 5'h14;
    @(negedge clk);
    lvl = 5'h00;
    rc(10'h337, 8'h80);
    u_host.wr(10'h337, 8'h2c);
    rc(10'h337, 8'h2c);
    fork
      u_host.wr(10'h336, 8'h00);
      begin
        @(negedge clk);
        pev = 8'h01;
        @(negedge clk);
        pev = 8'h00;
      end
    join
    rc(10'h336, 8'h01);
  endtask
  task automatic t_cal;
    rc_res = 16'hbeef;
    u_host.wr(10'h338, 8'h03);
    chk({6'h00, pll_en, if_en}, 8'h03);
    pll_done = 1'b1;
    if_done = 1'b1;
    pa_done = 1'b1;
    rc(10'h339, 8'h07);
    u_host.wr(10'h338, 8'h02);
    u_host.wr(10'h339, 8'hff);
    rc(10'h339, 8'h06);
    pll_done = 1'b0;
    rc(10'h339, 8'h04);
    cal_word = 6'h15;
    rc(10'h345, 8'h15);
    chk({2'h0, word_used}, 8'h15);
    u_host.wr(10'h346, 8'h55);
    repeat (2) @(negedge clk);
    chk({2'h0, word_used}, 8'h2a);
    rc(10'h346, 8'h55);
    rc(10'h34f, 8'hbe);
    rc(10'h350, 8'hef);
    u_host.wr(10'h359, 8'hfe);
    chk({4'h0, adc_in, adc_ref}, 8'h0e);
    rc(10'h359, 8'h0e);
  endtask
  task automatic t_tick(input ricb_byte_t div, input int n, input int lo, input int hi);
    int t0;
    u_host.wr(10'h32f, div);
    repeat (30) @(negedge clk);
    t0 = ticks;
    repeat (n) @(negedge clk);
    chk(8'((ticks - t0) >= lo && (ticks - t0) <= hi), 8'h01);
    rc(10'h32f, div);
  endtask
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    wrap_up();
  end
  initial begin
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    t_reset();
    t_events(10'h336, 8'hff, 1'b0);
    t_events(10'h337, 8'hd3, 1'b1);
    t_gates();
    t_cal();
    t_tick(8'h28, 2400, 9, 10);
    t_tick(8'h04, 246, 9, 10);
    t_tick(8'h00, 300, 0, 0);
    wrap_up();
  end
endmodule
`default_nettype wire
